// File: hw/dcd_dev.sv
// Device end: samples the link, decodes commands, tracks bank state.
// Assumes link pins change near the falling edge of the link clock
// and are stable around its rising edge, seen through ref_clk.
//
// What this block does
// - Activate opens an idle bank's row
// - Row stays open until that bank precharges
// - Precharge one bank, or all with AP
// - Precharged bank idle, reopens after precharge time
// - Precharge to idle bank restarts precharge time
// - Other banks usable during auto precharge
// - Write to active bank, AP closes after
// - Read to active bank, AP closes after
// - A12 low chops burst to four
// - Mode register set only when all idle
// - No-operation starts nothing new
// - Chip select high ignores command pins, not CKE or mask
// - Decode uses previous and current CKE
// - Refresh idle; with CKE falling, self refresh
// - CKE falling with NOP enters power down when all idle
// - CKE rising with NOP exits power down
// - Mask high discards write byte lane
`timescale 1ns/100ps
`include "dcd_regs.svh"
module dcd_dev
  import dcd_pkg::*;
#(
  parameter int TRP_CK = `DCD_TRP_CK,
  parameter int WL_CK = `DCD_WL_CK,
  parameter bit OTF_BC = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  dcd_if.dev link,
  output logic cmd_valid_reg,
  output dcd_cmd_t cmd_code_reg,
  output logic [2:0] cmd_bank_reg,
  output logic [12:0] cmd_addr_reg,
  output logic cmd_err_reg,
  output logic [7:0] bank_open_reg,
  output logic [7:0] bank_busy_reg,
  output dcd_pwr_t pwr_mode_reg,
  output logic wr_keep_valid_reg,
  output logic [1:0] wr_keep_reg
);

  // ==========================================================
  // Pin synchronisers
  // The clock and the pins pass the same two stages, so the sampled
  // pins line up with the detected rising edge.
  logic ck_s1_reg;
  logic ck_s2_reg;
  logic ck_s3_reg;
  logic [22:0] pin_s1_reg;
  logic [22:0] pin_s2_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ck_s1_reg <= 1'b0;
      ck_s2_reg <= 1'b0;
      ck_s3_reg <= 1'b0;
      pin_s1_reg <= 23'h7f_ffff;
      pin_s2_reg <= 23'h7f_ffff;
    end else if (ce) begin
      ck_s1_reg <= link.ck;
      ck_s2_reg <= ck_s1_reg;
      ck_s3_reg <= ck_s2_reg;
      pin_s1_reg <= {link.cs_n, link.ras_n, link.cas_n, link.we_n,
                     link.cke, link.ba, link.addr, link.dm};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  logic ck_rise;
  logic cs_n;
  logic [2:0] op;
  logic cke;
  logic [2:0] ba;
  logic [12:0] addr;
  logic [1:0] dm;
  assign ck_rise = ck_s2_reg & ~ck_s3_reg;
  assign cs_n = pin_s2_reg[22];
  assign op = pin_s2_reg[21:19];
  assign cke = pin_s2_reg[18];
  assign ba = pin_s2_reg[17:15];
  assign addr = pin_s2_reg[14:2];
  assign dm = pin_s2_reg[1:0];

  // ==========================================================
  // CKE history
  logic cke_prev_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cke_prev_reg <= 1'b1;
    end else if (ce && ck_rise) begin
      cke_prev_reg <= cke;
    end
  end

  // ==========================================================
  // Command decode
  dcd_cmd_t dec;
  logic idle_cmd;
  assign idle_cmd = cs_n || (op == `DCD_OP_NOP);

  always_comb begin
    dec = cmd_none;
    if (cke_prev_reg && cke) begin
      if (cs_n) begin
        dec = cmd_des;
      end else begin
        unique case (op)
          `DCD_OP_ACT: dec = cmd_act;
          `DCD_OP_PRE: dec = addr[`DCD_AP_BIT] ? cmd_prea : cmd_pre;
          `DCD_OP_WR: dec = cmd_wr;
          `DCD_OP_RD: dec = cmd_rd;
          `DCD_OP_MRS: dec = cmd_mrs;
          `DCD_OP_REF: dec = cmd_ref;
          `DCD_OP_ZQ: dec = addr[`DCD_AP_BIT] ? cmd_zql : cmd_zqs;
          `DCD_OP_NOP: dec = cmd_nop;
        endcase
      end
    end else if (cke_prev_reg && !cke) begin
      if (!cs_n && op == `DCD_OP_REF) begin
        dec = cmd_sre;
      end else if (idle_cmd) begin
        dec = cmd_pde;
      end
    end else if (!cke_prev_reg && cke) begin
      if (idle_cmd) begin
        dec = (pwr_mode_reg == pwr_selfref) ? cmd_srx : cmd_pdx;
      end
    end else begin
      dec = cmd_nop;
    end
  end

  // ==========================================================
  // Legality against bank state
  logic hit_open;
  logic hit_busy;
  logic all_idle;
  logic legal;
  assign hit_open = bank_open_reg[ba];
  assign hit_busy = bank_busy_reg[ba];
  assign all_idle = ~|bank_open_reg && ~|bank_busy_reg;

  always_comb begin
    legal = 1'b0;
    unique case (dec)
      cmd_act: legal = !hit_open && !hit_busy;
      cmd_rd, cmd_wr: legal = hit_open;
      cmd_mrs, cmd_ref, cmd_sre, cmd_pde, cmd_zql, cmd_zqs:
        legal = all_idle;
      cmd_pre, cmd_prea: legal = 1'b1;
      cmd_srx, cmd_pdx: legal = 1'b1;
      cmd_nop, cmd_des: legal = 1'b1;
      cmd_none: legal = 1'b0;
    endcase
  end

  logic go;
  dcd_tmr_t burst_len;
  assign go = ce && ck_rise && legal;
  // Chop only applies when on-the-fly burst selection is in use
  assign burst_len = (OTF_BC && !addr[`DCD_BC_BIT]) ?
                     dcd_tmr_t'(`DCD_BC4_CK) : dcd_tmr_t'(`DCD_BL8_CK);

  // ==========================================================
  // Command report
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_valid_reg <= 1'b0;
      cmd_err_reg <= 1'b0;
      cmd_code_reg <= cmd_nop;
      cmd_bank_reg <= 3'h0;
      cmd_addr_reg <= 13'h0000;
    end else if (ce) begin
      cmd_valid_reg <= go && dec != cmd_nop && dec != cmd_des;
      cmd_err_reg <= ck_rise && !legal;
      if (go && dec != cmd_nop && dec != cmd_des) begin
        cmd_code_reg <= dec;
        cmd_bank_reg <= ba;
        cmd_addr_reg <= addr;
      end
    end
  end

  // ==========================================================
  // Bank state
  // Auto precharge holds the bank busy for burst plus precharge time;
  // write latency is not added, a known simplification.
  dcd_tmr_t tmr_reg [`DCD_NBANK];
  logic ap;
  assign ap = addr[`DCD_AP_BIT];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bank_open_reg <= 8'h00;
      bank_busy_reg <= 8'h00;
      for (int b = 0; b < `DCD_NBANK; b++) begin
        tmr_reg[b] <= 8'h00;
      end
    end else if (ce && ck_rise) begin
      for (int b = 0; b < `DCD_NBANK; b++) begin
        if (legal && (dec == cmd_prea ||
            (dec == cmd_pre && ba == 3'(b)))) begin
          bank_open_reg[b] <= 1'b0;
          bank_busy_reg[b] <= 1'b1;
          tmr_reg[b] <= dcd_tmr_t'(TRP_CK);
        end else if (legal && dec == cmd_act && ba == 3'(b)) begin
          bank_open_reg[b] <= 1'b1;
        end else if (legal && ap && ba == 3'(b) &&
                     (dec == cmd_rd || dec == cmd_wr)) begin
          bank_open_reg[b] <= 1'b0;
          bank_busy_reg[b] <= 1'b1;
          tmr_reg[b] <= dcd_tmr_t'(TRP_CK) + burst_len;
        end else if (tmr_reg[b] != 8'h00) begin
          tmr_reg[b] <= tmr_reg[b] - 8'h01;
          if (tmr_reg[b] == 8'h01) begin
            bank_busy_reg[b] <= 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================
  // Power mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwr_mode_reg <= pwr_normal;
    end else if (go) begin
      unique case (pwr_mode_reg)
        pwr_normal: begin
          if (dec == cmd_pde) begin
            pwr_mode_reg <= pwr_down;
          end else if (dec == cmd_sre) begin
            pwr_mode_reg <= pwr_selfref;
          end
        end
        pwr_down: begin
          if (dec == cmd_pdx) begin
            pwr_mode_reg <= pwr_normal;
          end
        end
        pwr_selfref: begin
          if (dec == cmd_srx) begin
            pwr_mode_reg <= pwr_normal;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Write mask window
  // Mask is sampled once per link clock, not on both data edges.
  dcd_tmr_t wr_cnt_reg;
  dcd_tmr_t wr_len_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_cnt_reg <= 8'h00;
      wr_len_reg <= 8'h00;
      wr_keep_valid_reg <= 1'b0;
      wr_keep_reg <= 2'h0;
    end else if (ce) begin
      wr_keep_valid_reg <= 1'b0;
      if (go && dec == cmd_wr) begin
        wr_cnt_reg <= dcd_tmr_t'(WL_CK) + burst_len;
        wr_len_reg <= burst_len;
      end else if (ck_rise && wr_cnt_reg != 8'h00) begin
        wr_cnt_reg <= wr_cnt_reg - 8'h01;
        if (wr_cnt_reg <= wr_len_reg) begin
          wr_keep_valid_reg <= 1'b1;
          wr_keep_reg <= ~dm;
        end
      end
    end
  end

endmodule : dcd_dev

// File: hw/dcd_host.sv
// Controller end: makes the link clock and drives command pins.
// Assumes one request at a time; it refuses requests the bank or
// power state forbids instead of waiting for them.
`timescale 1ns/100ps
`include "dcd_regs.svh"
module dcd_host
  import dcd_pkg::*;
#(
  parameter int HALF = `DCD_CK_HALF,
  parameter int TRP_CK = `DCD_TRP_CK,
  parameter bit OTF_BC = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  dcd_if.host link,
  input wire logic req_valid,
  input dcd_cmd_t req_cmd,
  input wire logic [2:0] req_bank,
  input wire logic [12:0] req_addr,
  input wire logic [1:0] wr_mask,
  output logic req_ready_reg,
  output logic req_err_reg,
  output logic [7:0] bank_open_reg
);

  // ==========================================================
  // Link clock divider; pins change on its falling edge
  dcd_tmr_t div_reg;
  logic fall;
  logic wrap;
  assign wrap = (div_reg == dcd_tmr_t'(HALF - 1));
  assign fall = ce && wrap && link.ck;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_reg <= 8'h00;
      link.ck <= 1'b0;
    end else if (ce) begin
      div_reg <= wrap ? 8'h00 : div_reg + 8'h01;
      if (wrap) begin
        link.ck <= ~link.ck;
      end
    end
  end

  // ==========================================================
  // Request checking
  logic [7:0] busy_reg;
  dcd_tmr_t tmr_reg [`DCD_NBANK];
  dcd_pwr_t pwr_reg;
  logic all_idle;
  logic ok;
  assign all_idle = ~|bank_open_reg && ~|busy_reg;

  always_comb begin
    ok = 1'b0;
    unique case (req_cmd)
      cmd_act: ok = !bank_open_reg[req_bank] && !busy_reg[req_bank];
      cmd_rd, cmd_wr: ok = bank_open_reg[req_bank];
      cmd_mrs, cmd_ref, cmd_sre, cmd_pde, cmd_zql, cmd_zqs:
        ok = all_idle;
      cmd_pre, cmd_prea, cmd_nop, cmd_des: ok = 1'b1;
      cmd_srx: ok = (pwr_reg == pwr_selfref);
      cmd_pdx: ok = (pwr_reg == pwr_down);
      cmd_none: ok = 1'b0;
    endcase
    if (pwr_reg != pwr_normal && req_cmd != cmd_srx && req_cmd != cmd_pdx) begin
      ok = 1'b0;
    end
  end

  logic pend_reg;
  dcd_cmd_t pend_cmd_reg;
  logic [2:0] pend_bank_reg;
  logic [12:0] pend_addr_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_reg <= 1'b0;
      req_ready_reg <= 1'b1;
      req_err_reg <= 1'b0;
      pend_cmd_reg <= cmd_nop;
      pend_bank_reg <= 3'h0;
      pend_addr_reg <= 13'h0000;
    end else if (ce) begin
      req_err_reg <= 1'b0;
      if (req_valid && req_ready_reg) begin
        if (ok) begin
          pend_reg <= 1'b1;
          req_ready_reg <= 1'b0;
          pend_cmd_reg <= req_cmd;
          pend_bank_reg <= req_bank;
          pend_addr_reg <= req_addr;
        end else begin
          req_err_reg <= 1'b1;
        end
      end else if (fall && pend_reg) begin
        pend_reg <= 1'b0;
        req_ready_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Pin drive
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      link.cs_n <= 1'b1;
      {link.ras_n, link.cas_n, link.we_n} <= `DCD_OP_NOP;
      link.cke <= 1'b1;
      link.ba <= 3'h0;
      link.addr <= 13'h0000;
      link.dm <= 2'h0;
    end else if (fall) begin
      link.dm <= wr_mask;
      link.cs_n <= 1'b1;
      {link.ras_n, link.cas_n, link.we_n} <= `DCD_OP_NOP;
      if (pend_reg) begin
        link.cs_n <= 1'b0;
        link.cke <= 1'b1;
        link.ba <= pend_bank_reg;
        link.addr <= pend_addr_reg;
        unique case (pend_cmd_reg)
          cmd_act: {link.ras_n, link.cas_n, link.we_n} <= `DCD_OP_ACT;
          cmd_pre, cmd_prea: begin
            {link.ras_n, link.cas_n, link.we_n} <= `DCD_OP_PRE;
            link.addr[`DCD_AP_BIT] <= (pend_cmd_reg == cmd_prea);
          end
          cmd_wr: {link.ras_n, link.cas_n, link.we_n} <= `DCD_OP_WR;
          cmd_rd: {link.ras_n, link.cas_n, link.we_n} <= `DCD_OP_RD;
          cmd_mrs: {link.ras_n, link.cas_n, link.we_n} <= `DCD_OP_MRS;
          cmd_ref: {link.ras_n, link.cas_n, link.we_n} <= `DCD_OP_REF;
          cmd_sre: begin
            {link.ras_n, link.cas_n, link.we_n} <= `DCD_OP_REF;
            link.cke <= 1'b0;
          end
          cmd_pde: begin
            link.cs_n <= 1'b1;
            link.cke <= 1'b0;
          end
          cmd_srx, cmd_pdx: link.cs_n <= 1'b1;
          cmd_zql, cmd_zqs: begin
            {link.ras_n, link.cas_n, link.we_n} <= `DCD_OP_ZQ;
            link.addr[`DCD_AP_BIT] <= (pend_cmd_reg == cmd_zql);
          end
          cmd_des: link.cs_n <= 1'b1;
          cmd_nop, cmd_none: link.cs_n <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================================
  // Bank and power model, advanced on each link clock falling edge
  dcd_tmr_t burst_len;
  logic hit;
  assign burst_len = (OTF_BC && !pend_addr_reg[`DCD_BC_BIT]) ?
                     dcd_tmr_t'(`DCD_BC4_CK) : dcd_tmr_t'(`DCD_BL8_CK);
  assign hit = fall && pend_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bank_open_reg <= 8'h00;
      busy_reg <= 8'h00;
      pwr_reg <= pwr_normal;
      for (int b = 0; b < `DCD_NBANK; b++) begin
        tmr_reg[b] <= 8'h00;
      end
    end else if (fall) begin
      if (hit && (pend_cmd_reg == cmd_pde)) pwr_reg <= pwr_down;
      if (hit && (pend_cmd_reg == cmd_sre)) pwr_reg <= pwr_selfref;
      if (hit && (pend_cmd_reg == cmd_srx || pend_cmd_reg == cmd_pdx)) begin
        pwr_reg <= pwr_normal;
      end
      for (int b = 0; b < `DCD_NBANK; b++) begin
        if (hit && (pend_cmd_reg == cmd_prea ||
            (pend_cmd_reg == cmd_pre && pend_bank_reg == 3'(b)))) begin
          bank_open_reg[b] <= 1'b0;
          busy_reg[b] <= 1'b1;
          tmr_reg[b] <= dcd_tmr_t'(TRP_CK);
        end else if (hit && pend_cmd_reg == cmd_act &&
                     pend_bank_reg == 3'(b)) begin
          bank_open_reg[b] <= 1'b1;
        end else if (hit && pend_bank_reg == 3'(b) &&
                     pend_addr_reg[`DCD_AP_BIT] &&
                     (pend_cmd_reg == cmd_rd || pend_cmd_reg == cmd_wr)) begin
          bank_open_reg[b] <= 1'b0;
          busy_reg[b] <= 1'b1;
          tmr_reg[b] <= dcd_tmr_t'(TRP_CK) + burst_len;
        end else if (tmr_reg[b] != 8'h00) begin
          tmr_reg[b] <= tmr_reg[b] - 8'h01;
          if (tmr_reg[b] == 8'h01) busy_reg[b] <= 1'b0;
        end
      end
    end
  end

endmodule : dcd_host

// File: hw/dcd_if.sv
// Command and address pins between controller and memory device.
// Assumes the controller drives every pin; the device only listens.
`timescale 1ns/100ps
interface dcd_if;
  logic ck;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic cke;
  logic [2:0] ba;
  logic [12:0] addr;
  logic [1:0] dm;
  modport host (output ck, cs_n, ras_n, cas_n, we_n, cke, ba, addr, dm);
  modport dev (input ck, cs_n, ras_n, cas_n, we_n, cke, ba, addr, dm);
endinterface : dcd_if

// File: hw/dcd_pkg.sv
// Types shared by both ends of the command link.
// Assumes dcd_regs.svh is on the include path.
`include "dcd_regs.svh"
package dcd_pkg;
  typedef enum logic [3:0] {
    cmd_none, cmd_act, cmd_pre, cmd_prea, cmd_wr, cmd_rd, cmd_mrs,
    cmd_ref, cmd_sre, cmd_srx, cmd_pde, cmd_pdx, cmd_zql, cmd_zqs,
    cmd_nop, cmd_des
  } dcd_cmd_t;
  typedef enum logic [1:0] {pwr_normal, pwr_down, pwr_selfref} dcd_pwr_t;
  typedef logic [7:0] dcd_tmr_t;
endpackage : dcd_pkg

// File: hw/dcd_regs.svh
// Command codes, address bit positions and timing counts of the decoder.
// Assumes nothing; included by the package and by both ends.
`ifndef DCD_REGS_SVH
`define DCD_REGS_SVH
// ==========================================================
// Command pin codes {RAS#, CAS#, WE#} with CS# low
`define DCD_OP_MRS 3'h0
`define DCD_OP_REF 3'h1
`define DCD_OP_PRE 3'h2
`define DCD_OP_ACT 3'h3
`define DCD_OP_WR 3'h4
`define DCD_OP_RD 3'h5
`define DCD_OP_ZQ 3'h6
`define DCD_OP_NOP 3'h7
// ==========================================================
// Address bit positions
`define DCD_AP_BIT 10
`define DCD_BC_BIT 12
// ==========================================================
// Timing counts, in link clock cycles unless noted
`define DCD_TRP_CK 4
`define DCD_WL_CK 5
`define DCD_BL8_CK 4
`define DCD_BC4_CK 2
// Half period of the link clock in reference clock cycles
`define DCD_CK_HALF 4
`define DCD_NBANK 8
`endif

// File: tb/dcd_monitor.sv
// Checker of the command link pins between controller and device.
// Assumes it sees the link signals plainly, sampled on ref_clk.
`timescale 1ns/100ps
`include "dcd_regs.svh"
module dcd_monitor #(
  parameter int HALF = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic [2:0] ba,
  input wire logic [12:0] addr,
  input wire logic [1:0] dm
);
  // ==========================================================
  // Helper state: link clock edge and open banks seen on the wire
  logic ck_d;
  logic fall;
  logic iss;
  logic [2:0] op;
  logic [7:0] open_q;
  assign op = {ras_n, cas_n, we_n};
  assign fall = ck_d && !ck;
  assign iss = fall && !cs_n;
  always_ff @(posedge ref_clk) begin
    ck_d <= ck;
  end
  // Auto precharge counts as closed at the command, as the device does
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      open_q <= 8'h00;
    end else if (iss && op == `DCD_OP_ACT) begin
      open_q[ba] <= 1'b1;
    end else if (iss && op == `DCD_OP_PRE && addr[10]) begin
      open_q <= 8'h00;
    end else if (iss && op inside {`DCD_OP_PRE, `DCD_OP_WR, `DCD_OP_RD}
                 && (addr[10] || op == `DCD_OP_PRE)) begin
      open_q[ba] <= 1'b0;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_ck_half_period: assert property ($rose(ck) |-> ##HALF $fell(ck))
    else $error("link clock high time wrong");
  chk_pins_on_fall: assert property (
    $changed({cs_n, ras_n, cas_n, we_n, cke, ba, addr, dm}) |-> fall)
    else $error("link pins changed away from clock fall");
  chk_act_idle_bank: assert property (
    iss && op == `DCD_OP_ACT |-> !open_q[ba])
    else $error("activate to open bank");
  chk_rw_open_bank: assert property (
    iss && op inside {`DCD_OP_WR, `DCD_OP_RD} |-> open_q[ba])
    else $error("read or write to idle bank");
  chk_cmd_cke_high: assert property (
    iss && op inside {`DCD_OP_ACT, `DCD_OP_PRE, `DCD_OP_WR, `DCD_OP_RD,
    `DCD_OP_MRS, `DCD_OP_ZQ} |-> cke && $past(cke))
    else $error("command without clock enable high twice");
  chk_idle_only_cmds: assert property (
    iss && op inside {`DCD_OP_MRS, `DCD_OP_REF, `DCD_OP_ZQ} |-> open_q == 0)
    else $error("idle command with bank open");
  chk_cke_fall_legal: assert property (
    $fell(cke) |-> (cs_n || op inside {`DCD_OP_NOP, `DCD_OP_REF})
    && open_q == 0)
    else $error("clock enable fell with bad command");
  chk_cke_rise_legal: assert property (
    $rose(cke) |-> cs_n || op == `DCD_OP_NOP)
    else $error("clock enable rose with bad command");
  cov_act: cover property (iss && op == `DCD_OP_ACT);
  cov_wr_ap: cover property (iss && op == `DCD_OP_WR && addr[10]);
  cov_sre: cover property ($fell(cke) && !cs_n && op == `DCD_OP_REF);
endmodule : dcd_monitor

// File: tb/dcd_tb_top.sv
// Testbench: controller and device ends joined by one link.
// Assumes the hw/ files are compiled first; ce drops once to check the freeze.
`timescale 1ns/100ps
module dcd_tb_top;
  import dcd_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  dcd_cmd_t req_cmd = cmd_nop;
  logic [2:0] req_bank = 3'h0;
  logic [12:0] req_addr = 13'h0000;
  logic [1:0] wr_mask = 2'h0;
  logic ce = 1'b1;
  logic req_ready_reg, req_err_reg, cmd_valid_reg, cmd_err_reg, keep_v;
  dcd_cmd_t cmd_code_reg;
  logic [2:0] cmd_bank_reg;
  logic [12:0] cmd_addr_reg;
  logic [7:0] open_r, busy_r, host_open;
  dcd_pwr_t pwr_r;
  logic [1:0] keep_r;
  int failures = 0;
  int check_count = 0;
  int vcount = 0;
  int wcount = 0;
  int ecount = 0;
  int accepted = 0;
  dcd_if link ();
  dcd_host #(.HALF(4), .TRP_CK(2)) i_dcd_host (.ref_clk(ref_clk),
    .rst(rst), .ce(ce), .link(link), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
    .wr_mask(wr_mask), .req_ready_reg(req_ready_reg),
    .req_err_reg(req_err_reg), .bank_open_reg(host_open));
  dcd_dev #(.TRP_CK(2)) i_dcd_dev (.ref_clk(ref_clk), .rst(rst),
    .ce(ce), .link(link), .cmd_valid_reg(cmd_valid_reg),
    .cmd_code_reg(cmd_code_reg), .cmd_bank_reg(cmd_bank_reg),
    .cmd_addr_reg(cmd_addr_reg), .cmd_err_reg(cmd_err_reg),
    .bank_open_reg(open_r), .bank_busy_reg(busy_r), .pwr_mode_reg(pwr_r),
    .wr_keep_valid_reg(keep_v), .wr_keep_reg(keep_r));
  dcd_monitor #(.HALF(4)) i_dcd_monitor (.ref_clk(ref_clk), .rst(rst),
    .ck(link.ck), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .cke(link.cke), .ba(link.ba),
    .addr(link.addr), .dm(link.dm));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // Pulse counters, sampled mid-cycle to stay clear of the edge
  always @(negedge ref_clk) begin
    if (cmd_valid_reg === 1'b1) vcount++;
    if (keep_v === 1'b1) wcount++;
    if (cmd_err_reg === 1'b1) ecount++;
  end
  // ==========================================================
  // Compare, request and wait tasks
  task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp_vec
  task automatic cmp_cmd(input dcd_cmd_t got, input dcd_cmd_t exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t command %s expected %s", $time, got.name(),
               exp.name());
    end
  endtask : cmp_cmd
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cycles
  // Refused requests must leave the device untouched, so no pulse waited
  task automatic issue(input dcd_cmd_t c, input logic [2:0] b,
                       input logic [12:0] a, input logic ok);
    int v0;
    int n;
    logic err;
    v0 = vcount;
    n = 0;
    cycles(1);
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    req_valid = 1'b1;
    while (req_ready_reg !== 1'b1 && n < 100) begin
      cycles(1);
      n++;
    end
    cycles(1);
    req_valid = 1'b0;
    err = req_err_reg;
    cycles(1);
    err = err | req_err_reg;
    cmp_vec(err, !ok);
    if (ok) begin
      n = 0;
      while (vcount == v0 && n < 100) begin
        cycles(1);
        n++;
      end
      // No-operation and deselect must leave no pulse at all
      if (c inside {cmd_nop, cmd_des}) begin
        cmp_vec(vcount - v0, 13'h0000);
      end else begin
        accepted++;
        cmp_vec(vcount - v0, 13'h0001);
        cmp_cmd(cmd_code_reg, c);
        if (c inside {cmd_act, cmd_pre, cmd_wr, cmd_rd, cmd_mrs})
          cmp_vec(cmd_bank_reg, b);
        if (c == cmd_act)
          cmp_vec(cmd_addr_reg, a);
      end
    end
  endtask : issue
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_r !== 8'h00 && n < 200) begin
      cycles(1);
      n++;
    end
    cmp_vec(busy_r, 13'h0000);
  endtask : wait_idle
  // ==========================================================
  // Scenarios
  task automatic t_bank();
    issue(cmd_act, 3'h2, 13'h0123, 1'b1);
    cmp_vec(open_r, 13'h0004);
    cmp_vec(host_open, 13'h0004);
    issue(cmd_act, 3'h2, 13'h0040, 1'b0);
    issue(cmd_rd, 3'h5, 13'h0000, 1'b0);
    issue(cmd_nop, 3'h6, 13'h0abc, 1'b1);
    issue(cmd_des, 3'h6, 13'h0abc, 1'b1);
    // Freeze only in the low phase, so the link clock high time stays whole
    while (link.ck !== 1'b1) cycles(1);
    while (link.ck !== 1'b0) cycles(1);
    ce = 1'b0;
    cycles(40);
    ce = 1'b1;
    cmp_vec(open_r, 13'h0004);
    cmp_vec(vcount, accepted);
    $display("test bank done");
  endtask : t_bank
  task automatic t_write();
    int w0;
    wr_mask = 2'b01;
    w0 = wcount;
    issue(cmd_wr, 3'h2, 13'h0010, 1'b1);
    cycles(150);
    cmp_vec(wcount - w0, 13'h0002);
    cmp_vec(keep_r, 13'h0002);
    cmp_vec(open_r, 13'h0004);
    wr_mask = 2'b10;
    w0 = wcount;
    issue(cmd_wr, 3'h2, 13'h1410, 1'b1);
    cycles(150);
    cmp_vec(wcount - w0, 13'h0004);
    cmp_vec(keep_r, 13'h0001);
    cmp_vec(open_r, 13'h0000);
    $display("test write done");
  endtask : t_write
  task automatic t_auto();
    wait_idle();
    issue(cmd_act, 3'h2, 13'h0001, 1'b1);
    issue(cmd_act, 3'h3, 13'h0002, 1'b1);
    issue(cmd_rd, 3'h2, 13'h1400, 1'b1);
    cmp_vec(open_r, 13'h0008);
    cmp_vec(busy_r[2], 13'h0001);
    issue(cmd_act, 3'h2, 13'h0003, 1'b0);
    issue(cmd_rd, 3'h3, 13'h0020, 1'b1);
    $display("test auto precharge done");
  endtask : t_auto
  task automatic t_pre();
    issue(cmd_pre, 3'h3, 13'h0000, 1'b1);
    cmp_vec(open_r, 13'h0000);
    issue(cmd_pre, 3'h3, 13'h0000, 1'b1);
    cmp_vec(busy_r[3], 13'h0001);
    wait_idle();
    issue(cmd_act, 3'h1, 13'h0004, 1'b1);
    issue(cmd_act, 3'h4, 13'h0005, 1'b1);
    issue(cmd_prea, 3'h0, 13'h0000, 1'b1);
    cmp_vec(open_r, 13'h0000);
    $display("test precharge done");
  endtask : t_pre
  task automatic t_idle();
    dcd_cmd_t list [4];
    list = '{cmd_mrs, cmd_ref, cmd_zql, cmd_zqs};
    wait_idle();
    issue(cmd_act, 3'h0, 13'h0006, 1'b1);
    issue(cmd_mrs, 3'h1, 13'h0000, 1'b0);
    issue(cmd_pre, 3'h0, 13'h0000, 1'b1);
    foreach (list[i]) begin
      wait_idle();
      issue(list[i], 3'h2, 13'h0000, 1'b1);
    end
    $display("test idle commands done");
  endtask : t_idle
  task automatic t_power();
    wait_idle();
    issue(cmd_pde, 3'h0, 13'h0000, 1'b1);
    cmp_vec(pwr_r, pwr_down);
    issue(cmd_pdx, 3'h0, 13'h0000, 1'b1);
    cmp_vec(pwr_r, pwr_normal);
    issue(cmd_sre, 3'h0, 13'h0000, 1'b1);
    cmp_vec(pwr_r, pwr_selfref);
    issue(cmd_srx, 3'h0, 13'h0000, 1'b1);
    cmp_vec(pwr_r, pwr_normal);
    cmp_vec(ecount, 13'h0000);
    cmp_vec(vcount, accepted);
    $display("test power done");
  endtask : t_power
  // ==========================================================
  // Verdict, main sequence and watchdog
  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    cycles(3);
    rst = 1'b0;
    cycles(4);
    t_bank();
    t_write();
    t_auto();
    t_pre();
    t_idle();
    t_power();
    finish_test();
  end
  // Whole run needs some 1000 cycles; twenty-four times that is a hang
  initial begin
    #(24000 * 20);
    failures++;
    $display("MISMATCH %0t watchdog expired", $time);
    finish_test();
  end
endmodule : dcd_tb_top
